// [wpf_crc_unit.sv]
// wpf_crc_unit: one wakeup filter, running crc over masked frame bytes.
// assumes rx bytes arrive one per valid cycle, sof on the first da byte.
`timescale 1ns/1ps
module wpf_crc_unit #(
   parameter int MASK_W = 128  // pattern span in bytes
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              rx_valid_i,
   input  wire logic              rx_sof_i,
   input  wire logic              rx_eof_i,
   input  wire logic              rx_good_i,
   input  wire logic [7:0]        rx_data_i,
   input  wire logic [31:0]       cfg_i,
   input  wire logic [MASK_W-1:0] mask_i,
   output logic                   hit_o
);

   logic [8:0]  pos_q;    // byte position of next byte
   logic [15:0] crc_q;    // running crc
   logic        mcast_q;  // group bit of destination
   logic [8:0]  pos;      // position of current byte
   logic [15:0] crc_in;   // crc before current byte
   logic [15:0] crc_d;    // crc after current byte
   logic        mcast;    // group bit seen for this frame
   logic [8:0]  rel;      // position relative to offset
   logic [1:0]  atype;    // address type field
   logic        type_ok;  // frame class accepted

   // per-byte crc step
   always_comb begin
      pos    = rx_sof_i ? 9'd0 : pos_q;
      crc_in = rx_sof_i ? wpf_pkg::WPF_CRC_PRESET : crc_q;
      mcast  = rx_sof_i ? rx_data_i[0] : mcast_q;
      rel    = pos - {1'b0, cfg_i[wpf_pkg::WPF_CFG_OFF_LSB +: 8]};
      crc_d  = crc_in;
      // include byte offset+j only when mask bit j is set
      if (pos >= {1'b0, cfg_i[wpf_pkg::WPF_CFG_OFF_LSB +: 8]} && rel < MASK_W
          && mask_i[rel[6:0]]) begin
         crc_d = wpf_pkg::wpf_crc_byte(crc_in, rx_data_i);
      end
      atype   = cfg_i[wpf_pkg::WPF_CFG_TYPE_LSB +: 2];
      type_ok = atype[0] || (atype[1] == mcast);
   end

   // frame state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos_q   <= 9'd0;
         crc_q   <= wpf_pkg::WPF_CRC_PRESET;
         mcast_q <= 1'b0;
      end else if (rx_valid_i) begin
         pos_q   <= (pos == 9'h1ff) ? pos : pos + 9'd1;  // saturate on long frames
         crc_q   <= crc_d;
         mcast_q <= mcast;
      end
   end

   // match decision at the last byte
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hit_o <= 1'b0;
      end else begin
         hit_o <= rx_valid_i && rx_eof_i && rx_good_i && cfg_i[wpf_pkg::WPF_CFG_EN_BIT]
                  && type_ok
                  && (crc_d == cfg_i[wpf_pkg::WPF_CFG_CRC_LSB +: 16]);
      end
   end

   disabled_no_hit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !cfg_i[wpf_pkg::WPF_CFG_EN_BIT] && $stable(cfg_i) |=> !hit_o)
      else $error("disabled filter reported a hit");

   hit_needs_eof_a: assert property (@(posedge clk_i) disable iff (rst_i)
      hit_o |-> $past(rx_valid_i && rx_eof_i && rx_good_i))
      else $error("hit without a good frame end");

endmodule // wpf_crc_unit

// [wpf_filter_top.sv]
// wpf_filter_top: wakeup pattern filters and perfect address filter with regs.
// assumes classic wishbone master, mac rx byte stream and an image loader.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module wpf_filter_top #(
   parameter int NUM_WUF = 32,   // wakeup filters
   parameter int NUM_PF  = 33,   // perfect filter entries
   parameter int MASK_W  = 128   // byte mask width
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [11:0]       wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic                   wb_ack_o,
   output logic [31:0]            wb_dat_o,
   // mac receive byte stream
   input  wire logic              rx_valid_i,
   input  wire logic              rx_sof_i,
   input  wire logic              rx_eof_i,
   input  wire logic              rx_good_i,
   input  wire logic [7:0]        rx_data_i,
   // eeprom/otp image of filter zero
   input  wire logic              img_load_i,
   input  wire logic              img_valid_i,
   input  wire logic [31:0]       img_cfg_i,
   input  wire logic [MASK_W-1:0] img_mask_i,
   // soft resets that restore filter zero
   input  wire logic              usb_reset_i,
   input  wire logic              lite_soft_reset_i,
   // events
   output logic                   wake_o,
   output logic                   pf_hit_o,
   output logic                   irq_o
);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   localparam int IDX_W = $clog2(NUM_WUF);  // index field width

   // bus handshake states, one-hot
   typedef enum logic [1:0] {
      WPF_BUS_IDLE = 2'b01,  // waiting for a request
      WPF_BUS_ACK  = 2'b10   // ack stands for this cycle
   } wpf_bus_t;

   logic [31:0]                  cfg_q  [NUM_WUF];  // filter config words
   logic [MASK_W-1:0]            mask_q [NUM_WUF];  // filter byte masks
   logic [31:0]                  pfh_q  [NUM_PF];   // entry first word
   logic [31:0]                  pfl_q  [NUM_PF];   // entry second word
   logic [31:0]                  img_cfg_q;         // last loaded config image
   logic [MASK_W-1:0]            img_mask_q;        // last loaded mask image
   wpf_bus_t                     bus_q;             // handshake state
   wpf_bus_t                     bus_d;             // next handshake state
   logic [31:0]                  dat_q;             // read data, held with ack
   logic [31:0]                  rdata;             // data of addressed register
   logic                         req;               // cyc and stb both high
   logic                         wr_commit;         // write lands on this edge
   logic [11:0]                  cfg_rel;           // offset in config window
   logic [11:0]                  mask_rel;          // offset in mask window
   logic [11:0]                  pf_rel;            // offset in entry window
   logic                         sel_cfg;           // config window addressed
   logic                         sel_mask;          // mask window addressed
   logic                         sel_pf;            // entry window addressed
   logic                         sel_stat;          // status addressed
   logic                         sel_imsk;          // interrupt mask addressed
   logic                         sel_idx;           // index register addressed
   logic                         restore;           // usb or lite reset
   logic [3:0]                   bpos_q;            // next byte position, stops at 12
   logic [3:0]                   bpos;              // position of current byte
   logic [47:0]                  da_q;              // destination address of frame
   logic [47:0]                  sa_q;              // source address of frame
   logic                         frame_end;         // good last byte this cycle
   logic                         pf_match;          // a valid entry equals an address
   logic                         pf_ev_q;           // perfect filter hit pulse
   logic [NUM_WUF-1:0]           wuf_hit;           // per filter hit pulse
   logic                         wuf_any;           // some filter hit
   logic [IDX_W-1:0]             wake_idx;          // lowest hitting filter
   logic                         wake_q;            // wakeup pulse
   logic [IDX_W-1:0]             idx_q;             // matching filter index
   logic [wpf_pkg::WPF_ST_W-1:0] stat_q;            // sticky events
   logic [wpf_pkg::WPF_ST_W-1:0] st_set;            // events this cycle
   logic [wpf_pkg::WPF_ST_W-1:0] st_clr;            // write one to clear
   logic [wpf_pkg::WPF_ST_W-1:0] imsk_q;            // interrupt mask
   logic                         irq_q;             // interrupt level

   // true when a byte address lies in a window of span bytes
   function automatic logic in_win(input logic [11:0] a,
                                   input logic [11:0] base,
                                   input int          span);
      return (int'(a) >= int'(base)) && (int'(a) < int'(base) + span);
   endfunction

   // merge write data into a word under the byte selects
   function automatic logic [31:0] merge_sel(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction

   // address decode; the mask layout needs MASK_W of 128
   always_comb begin
      req       = wb_cyc_i && wb_stb_i;
      wr_commit = req && wb_we_i && (bus_q == WPF_BUS_ACK);
      cfg_rel   = wb_adr_i - wpf_pkg::WPF_CFG_BASE;
      mask_rel  = wb_adr_i - wpf_pkg::WPF_MASK_BASE;
      pf_rel    = wb_adr_i - wpf_pkg::WPF_PF_BASE;
      sel_cfg   = in_win(wb_adr_i, wpf_pkg::WPF_CFG_BASE, 4 * NUM_WUF);
      sel_mask  = in_win(wb_adr_i, wpf_pkg::WPF_MASK_BASE, 16 * NUM_WUF);
      sel_pf    = in_win(wb_adr_i, wpf_pkg::WPF_PF_BASE, 8 * NUM_PF);
      sel_stat  = (wb_adr_i[11:2] == wpf_pkg::WPF_STAT_OFF[11:2]);
      sel_imsk  = (wb_adr_i[11:2] == wpf_pkg::WPF_IMSK_OFF[11:2]);
      sel_idx   = (wb_adr_i[11:2] == wpf_pkg::WPF_IDX_OFF[11:2]);
      restore   = usb_reset_i || lite_soft_reset_i;
   end

   // ack one cycle after the request, then idle for a cycle
   always_comb begin
      unique case (bus_q)
         WPF_BUS_IDLE: bus_d = req ? WPF_BUS_ACK : WPF_BUS_IDLE;
         WPF_BUS_ACK:  bus_d = WPF_BUS_IDLE;
         default:      bus_d = WPF_BUS_IDLE;  // illegal code recovers
      endcase
   end

   // handshake state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_q <= WPF_BUS_IDLE;
      end else begin
         bus_q <= bus_d;
      end
   end

   // read data captured as ack rises, stands with it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0000_0000;
      end else if (req && bus_q == WPF_BUS_IDLE) begin
         dat_q <= rdata;
      end
   end

   // read multiplexer, unmapped addresses read zero
   always_comb begin
      rdata = 32'h0000_0000;
      for (int i = 0; i < NUM_WUF; i++) begin
         if (sel_cfg && cfg_rel[11:2] == 10'(i)) begin
            rdata = cfg_q[i];
         end
         if (sel_mask && mask_rel[11:4] == 8'(i)) begin
            rdata = mask_q[i][{mask_rel[3:2], 5'd0} +: 32];
         end
      end
      for (int e = 0; e < NUM_PF; e++) begin
         if (sel_pf && pf_rel[11:3] == 9'(e)) begin
            rdata = pf_rel[2] ? pfl_q[e] : pfh_q[e];
         end
      end
      if (sel_stat) begin
         rdata = 32'(stat_q);
      end
      if (sel_imsk) begin
         rdata = 32'(imsk_q);
      end
      if (sel_idx) begin
         rdata = 32'(idx_q);
      end
   end

   // image of filter zero, kept for later restores
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         img_cfg_q  <= wpf_pkg::WPF_CFG_RST;
         img_mask_q <= MASK_W'(wpf_pkg::WPF_MASK_RST);
      end else if (img_load_i) begin
         // no valid image leaves zero behind
         img_cfg_q  <= img_valid_i ? (img_cfg_i & wpf_pkg::WPF_CFG_WMASK)
                                   : wpf_pkg::WPF_CFG_RST;
         img_mask_q <= img_valid_i ? img_mask_i : MASK_W'(wpf_pkg::WPF_MASK_RST);
      end
   end

   // filter config words; restore beats a load, a load beats software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_WUF; i++) begin
            cfg_q[i] <= wpf_pkg::WPF_CFG_RST;
         end
      end else begin
         for (int i = 0; i < NUM_WUF; i++) begin
            if (i == 0 && restore) begin
               cfg_q[i] <= img_cfg_q;
            end else if (i == 0 && img_load_i) begin
               cfg_q[i] <= img_valid_i ? (img_cfg_i & wpf_pkg::WPF_CFG_WMASK)
                                       : wpf_pkg::WPF_CFG_RST;
            end else if (wr_commit && sel_cfg && cfg_rel[11:2] == 10'(i)) begin
               // reserved bits 30:26 stay zero
               cfg_q[i] <= merge_sel(cfg_q[i], wb_dat_i, wb_sel_i)
                           & wpf_pkg::WPF_CFG_WMASK;
            end
         end
      end
   end

   // byte masks, four words per filter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_WUF; i++) begin
            mask_q[i] <= MASK_W'(wpf_pkg::WPF_MASK_RST);
         end
      end else begin
         for (int i = 0; i < NUM_WUF; i++) begin
            if (i == 0 && restore) begin
               mask_q[i] <= img_mask_q;
            end else if (i == 0 && img_load_i) begin
               mask_q[i] <= img_valid_i ? img_mask_i
                                        : MASK_W'(wpf_pkg::WPF_MASK_RST);
            end else if (wr_commit && sel_mask && mask_rel[11:4] == 8'(i)) begin
               mask_q[i][{mask_rel[3:2], 5'd0} +: 32] <=
                  merge_sel(mask_q[i][{mask_rel[3:2], 5'd0} +: 32],
                            wb_dat_i, wb_sel_i);
            end
         end
      end
   end

   // perfect filter entries, two words each
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int e = 0; e < NUM_PF; e++) begin
            pfh_q[e] <= wpf_pkg::WPF_PF_RST;
            pfl_q[e] <= wpf_pkg::WPF_PF_RST;
         end
      end else begin
         for (int e = 0; e < NUM_PF; e++) begin
            if (wr_commit && sel_pf && pf_rel[11:3] == 9'(e)) begin
               if (pf_rel[2]) begin
                  pfl_q[e] <= merge_sel(pfl_q[e], wb_dat_i, wb_sel_i);
               end else begin
                  // reserved bits 29:16 stay zero
                  pfh_q[e] <= merge_sel(pfh_q[e], wb_dat_i, wb_sel_i)
                              & wpf_pkg::WPF_PF_HI_WMASK;
               end
            end
         end
      end
   end

   // position of the byte on the bus now
   always_comb begin
      bpos      = rx_sof_i ? 4'd0 : bpos_q;
      frame_end = rx_valid_i && rx_eof_i && rx_good_i;
   end

   // address capture, first frame byte into address bits 7:0
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bpos_q <= 4'd0;
         da_q   <= 48'h0;
         sa_q   <= 48'h0;
      end else if (rx_valid_i) begin
         bpos_q <= (bpos == 4'd12) ? bpos : bpos + 4'd1;
         if (bpos < 4'd6) begin
            da_q[8*bpos +: 8] <= rx_data_i;
         end else if (bpos < 4'd12) begin
            sa_q[8*(bpos - 4'd6) +: 8] <= rx_data_i;
         end
      end
   end

   // compare every valid entry with its selected address
   always_comb begin
      pf_match = 1'b0;
      for (int e = 0; e < NUM_PF; e++) begin
         if (pfh_q[e][wpf_pkg::WPF_PF_VALID_BIT]
             && {pfh_q[e][15:0], pfl_q[e]}
                == (pfh_q[e][wpf_pkg::WPF_PF_SRC_BIT] ? sa_q : da_q)) begin
            pf_match = 1'b1;
         end
      end
   end

   // perfect filter hit pulse at frame end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pf_ev_q <= 1'b0;
      end else begin
         pf_ev_q <= frame_end && pf_match;
      end
   end

   // one crc engine per wakeup filter
   for (genvar g = 0; g < NUM_WUF; g++) begin : g_wuf
      wpf_crc_unit #(
         .MASK_W (MASK_W)
      ) u_crc (
         .clk_i      (clk_i),
         .rst_i      (rst_i),
         .rx_valid_i (rx_valid_i),
         .rx_sof_i   (rx_sof_i),
         .rx_eof_i   (rx_eof_i),
         .rx_good_i  (rx_good_i),
         .rx_data_i  (rx_data_i),
         .cfg_i      (cfg_q[g]),
         .mask_i     (mask_q[g]),
         .hit_o      (wuf_hit[g])
      );
   end

   // lowest numbered hitting filter wins
   always_comb begin
      wuf_any  = |wuf_hit;
      wake_idx = '0;
      for (int i = NUM_WUF - 1; i >= 0; i--) begin
         if (wuf_hit[i]) begin
            wake_idx = IDX_W'(i);
         end
      end
   end

   // wakeup pulse and index, index kept while the flag stands
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_q <= 1'b0;
         idx_q  <= '0;
      end else begin
         wake_q <= wuf_any;
         if (wuf_any && (!stat_q[wpf_pkg::WPF_ST_WAKE] || st_clr[wpf_pkg::WPF_ST_WAKE])) begin
            idx_q <= wake_idx;
         end
      end
   end

   // events and write-one clears of this cycle
   always_comb begin
      st_set                       = '0;
      st_set[wpf_pkg::WPF_ST_WAKE] = wuf_any;
      st_set[wpf_pkg::WPF_ST_PF]   = pf_ev_q;
      st_clr = (wr_commit && sel_stat) ? wb_dat_i[wpf_pkg::WPF_ST_W-1:0] : '0;
   end

   // sticky status, a new event beats a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_q <= '0;
      end else begin
         stat_q <= (stat_q & ~st_clr) | st_set;
      end
   end

   // interrupt mask and level output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         imsk_q <= '0;
         irq_q  <= 1'b0;
      end else begin
         if (wr_commit && sel_imsk) begin
            imsk_q <= wb_dat_i[wpf_pkg::WPF_ST_W-1:0];
         end
         irq_q <= |(stat_q & imsk_q);
      end
   end

   // outputs straight from flops
   assign wb_ack_o = bus_q[1];
   assign wb_dat_o = dat_q;
   assign wake_o   = wake_q;
   assign pf_hit_o = pf_ev_q;
   assign irq_o    = irq_q;

   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack stood longer than one cycle");

   wake_sets_flag_a: assert property (wuf_any |=> stat_q[wpf_pkg::WPF_ST_WAKE])
      else $error("filter hit did not set the wakeup flag");

   idx_recorded_a: assert property (wuf_any && !stat_q[wpf_pkg::WPF_ST_WAKE] |=> idx_q == $past(wake_idx))
      else $error("matching filter index not recorded");

   pf_hit_event_a: assert property (frame_end && pf_match |=> pf_hit_o)
      else $error("perfect filter match gave no hit");

   restore_image_a: assert property (restore |=> cfg_q[0] == $past(img_cfg_q) && mask_q[0] == $past(img_mask_q))
      else $error("filter zero not restored from image");

endmodule // wpf_filter_top

// [wpf_filter_top_tb_top.sv]
// wpf_filter_top_tb_top: register, reset and wakeup checks of the filter block.
// assumes a classic wishbone slave and an eeprom or otp image that the bench drives itself.
`timescale 1ns/1ps
module wpf_filter_top_tb_top;
   logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, lite_soft_reset = 0;  // bench drives
   logic        usb = 0, ild = 0, ivld = 0;                       // image and usb reset
   logic [31:0] icfg = 32'h0;
   logic [127:0] imask = 128'h0;
   int          n_wake = 0, n_pf = 0;                             // event pulses seen
   logic        ack, wake, pfh, irq, rv, rs, re, rg;             // design and mac model drive
   logic [3:0]  sel = 4'h0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wd = 32'h0, rd, q;
   logic [7:0]  rdat;
   int          err_count = 0, n_tests = 0;
   always #5 clk_i = ~clk_i;
   wpf_mac_rx_model u_mac (.clk_i(clk_i), .valid_o(rv), .sof_o(rs), .eof_o(re),
      .good_o(rg), .data_o(rdat));
   wpf_filter_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_ack_o(ack),
      .wb_dat_o(rd), .rx_valid_i(rv), .rx_sof_i(rs), .rx_eof_i(re), .rx_good_i(rg),
      .rx_data_i(rdat), .img_load_i(ild), .img_valid_i(ivld), .img_cfg_i(icfg),
      .img_mask_i(imask), .usb_reset_i(usb), .lite_soft_reset_i(lite_soft_reset), .wake_o(wake),
      .pf_hit_o(pfh), .irq_o(irq));
   // count one-cycle event pulses
   always @(posedge clk_i) begin
      if (wake === 1'b1) n_wake++;
      if (pfh === 1'b1) n_pf++;
   end
   // one classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc, we, adr, wd, sel} <= {1'b1, w, a, d, 4'hf};
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rd;
      {cyc, we} <= 2'b00;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   // irq follows status and mask two edges after a write
   task automatic irqchk(input logic exp);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, {31'h0, exp});
   endtask
   // reflected crc-16, written apart from the design's own
   function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
      c ^= {8'h00, d};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      return c;
   endfunction
   // reset values, reserved bits, lite reset restore
   task automatic t_regs;
      rdchk(wpf_pkg::WPF_CFG_BASE, 32'h0);
      wb(1'b1, wpf_pkg::WPF_CFG_BASE, 32'hffff_ffff);
      rdchk(wpf_pkg::WPF_CFG_BASE, 32'h83ff_ffff);
      @(posedge clk_i) lite_soft_reset <= 1'b1;
      @(posedge clk_i) lite_soft_reset <= 1'b0;
      rdchk(wpf_pkg::WPF_CFG_BASE, 32'h0);
      wb(1'b1, wpf_pkg::WPF_MASK_BASE + 12'h00c, 32'ha5a5_0f0f);
      rdchk(wpf_pkg::WPF_MASK_BASE + 12'h00c, 32'ha5a5_0f0f);
      wb(1'b1, wpf_pkg::WPF_PF_BASE, 32'h7fff_ffff);  // valid left clear
      rdchk(wpf_pkg::WPF_PF_BASE, 32'h4000_ffff);
      $display("register test done");
   endtask
   // image load, usb and lite restore of filter zero
   task automatic t_image;
      @(posedge clk_i);
      {ild, ivld, icfg, imask} <= {1'b1, 1'b1, 32'hffff_1234, {4{32'h0000_00ff}}};
      @(posedge clk_i) ild <= 1'b0;
      rdchk(wpf_pkg::WPF_CFG_BASE, 32'h83ff_1234);
      wb(1'b1, wpf_pkg::WPF_CFG_BASE, 32'h0);
      wb(1'b1, wpf_pkg::WPF_MASK_BASE, 32'h0);
      @(posedge clk_i) usb <= 1'b1;
      @(posedge clk_i) usb <= 1'b0;
      rdchk(wpf_pkg::WPF_CFG_BASE, 32'h83ff_1234);
      rdchk(wpf_pkg::WPF_MASK_BASE, 32'h0000_00ff);
      @(posedge clk_i) {ild, ivld} <= 2'b10;
      @(posedge clk_i) ild <= 1'b0;
      rdchk(wpf_pkg::WPF_CFG_BASE, 32'h0);
      @(posedge clk_i) lite_soft_reset <= 1'b1;
      @(posedge clk_i) lite_soft_reset <= 1'b0;
      rdchk(wpf_pkg::WPF_MASK_BASE, 32'h0);
      $display("image test done");
   endtask
   // perfect filter on destination, then on source
   task automatic t_pf;
      wb(1'b1, wpf_pkg::WPF_PF_BASE + 12'h004, 32'h1312_1110);
      wb(1'b1, wpf_pkg::WPF_PF_BASE, 32'h8000_1514);
      u_mac.send(14);
      repeat (20) @(posedge clk_i);
      rdchk(wpf_pkg::WPF_STAT_OFF, 32'h3);
      wb(1'b1, wpf_pkg::WPF_STAT_OFF, 32'h3);
      wb(1'b1, wpf_pkg::WPF_PF_BASE, 32'h4000_1514);  // valid cleared first
      wb(1'b1, wpf_pkg::WPF_PF_BASE, 32'hc000_1514);
      u_mac.send(14);
      repeat (20) @(posedge clk_i);
      rdchk(wpf_pkg::WPF_STAT_OFF, 32'h1);
      chk(32'(n_wake), 32'h3);
      chk(32'(n_pf), 32'h1);
      $display("perfect filter test done");
   endtask
   // filter one: bytes 3 and 5, off then on, then irq mask and clear
   task automatic t_wake;
      logic [15:0] c;
      for (int i = 0; i < 14; i++) u_mac.frame[i] = 8'h10 + 8'(i);
      c = crc16(crc16(16'hffff, 8'h13), 8'h15);
      wb(1'b1, wpf_pkg::WPF_MASK_BASE + 12'h010, 32'h5);
      wb(1'b1, wpf_pkg::WPF_CFG_BASE + 12'h004, {8'h01, 8'h03, c});
      u_mac.send(14);
      repeat (20) @(posedge clk_i);
      rdchk(wpf_pkg::WPF_STAT_OFF, 32'h0);
      wb(1'b1, wpf_pkg::WPF_CFG_BASE + 12'h004, {8'h81, 8'h03, c});
      u_mac.send(14);
      repeat (20) @(posedge clk_i);
      rdchk(wpf_pkg::WPF_STAT_OFF, 32'h1);
      rdchk(wpf_pkg::WPF_IDX_OFF, 32'h1);
      irqchk(1'b0);  // masked, no interrupt
      wb(1'b1, wpf_pkg::WPF_IMSK_OFF, 32'h1);
      irqchk(1'b1);  // unmasked event raises irq
      wb(1'b1, wpf_pkg::WPF_STAT_OFF, 32'h1);
      irqchk(1'b0);  // write one clears
      rdchk(wpf_pkg::WPF_STAT_OFF, 32'h0);
      $display("wakeup test done");
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // main sequence after six reset cycles
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_image;
      t_wake;
      t_pf;
      complete_run;
   end
   // watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      complete_run;
   end
endmodule // wpf_filter_top_tb_top

// [wpf_mac_rx_model.sv]
// wpf_mac_rx_model: mac receive path model, one byte per clock.
// assumes the bench fills frame[] and then calls send with the length.
`timescale 1ns/1ps
module wpf_mac_rx_model (
   input  wire logic       clk_i,
   output logic            valid_o,
   output logic            sof_o,
   output logic            eof_o,
   output logic            good_o,
   output logic [7:0]      data_o
);
   logic [7:0] frame [16];  // bytes of the next frame, da first
   initial begin
      {valid_o, sof_o, eof_o, good_o} = 4'h0;
      data_o = 8'h00;
   end
   // sof on the first da byte, good flagged with eof
   task automatic send(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         {valid_o, sof_o, eof_o, good_o} <= {1'b1, i == 0, i == n - 1, i == n - 1};
         data_o <= frame[i];
      end
      @(posedge clk_i);
      {valid_o, sof_o, eof_o, good_o} <= 4'h0;
      data_o <= ~data_o;  // idle line never repeats the last byte
   endtask
endmodule // wpf_mac_rx_model

// [wpf_pkg.sv]
// wpf_pkg: constants shared by the wakeup and perfect address filter block.
// assumes a 32-bit classic wishbone register bus with byte addresses.
package wpf_pkg;

   // register offsets (byte addresses)
   localparam logic [11:0] WPF_CFG_BASE  = 12'h150;  // filter config words
   localparam logic [11:0] WPF_MASK_BASE = 12'h200;  // byte mask blocks
   localparam logic [11:0] WPF_PF_BASE   = 12'h400;  // perfect filter entries
   localparam logic [11:0] WPF_STAT_OFF  = 12'h540;  // sticky event status
   localparam logic [11:0] WPF_IMSK_OFF  = 12'h544;  // interrupt mask
   localparam logic [11:0] WPF_IDX_OFF   = 12'h548;  // matching filter index

   // filter config fields
   localparam int WPF_CFG_EN_BIT   = 31;  // filter enable
   localparam int WPF_CFG_TYPE_LSB = 24;  // address type, two bits
   localparam int WPF_CFG_OFF_LSB  = 16;  // pattern offset, eight bits
   localparam int WPF_CFG_CRC_LSB  = 0;   // expected crc, sixteen bits
   localparam logic [31:0] WPF_CFG_WMASK = 32'h83ff_ffff;  // 30:26 read zero

   // perfect filter entry fields
   localparam int WPF_PF_VALID_BIT = 31;  // entry valid
   localparam int WPF_PF_SRC_BIT   = 30;  // compare source address
   localparam logic [31:0] WPF_PF_HI_WMASK = 32'hc000_ffff;  // 29:16 read zero

   // status bit positions
   localparam int WPF_ST_WAKE = 0;  // wakeup frame received flag
   localparam int WPF_ST_PF   = 1;  // perfect filter hit
   localparam int WPF_ST_W    = 2;  // status width

   // reset values
   localparam logic [31:0]  WPF_CFG_RST  = 32'h0000_0000;
   localparam logic [127:0] WPF_MASK_RST = 128'h0;
   localparam logic [31:0]  WPF_PF_RST   = 32'h0000_0000;

   // crc-16, polynomial 8005 processed lsb first (reflected form)
   localparam logic [15:0] WPF_CRC_POLY_REFL = 16'ha001;
   localparam logic [15:0] WPF_CRC_PRESET    = 16'hffff;

   // one byte through the crc, lsb first
   function automatic logic [15:0] wpf_crc_byte(input logic [15:0] crc,
                                                input logic [7:0]  data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int b = 0; b < 8; b++) begin
         c = c[0] ? ((c >> 1) ^ WPF_CRC_POLY_REFL) : (c >> 1);
      end
      return c;
   endfunction

endpackage
